// [rtl/adc_result_fifo.sv]
// Conversion result buffer with host pins and an APB status, control and data port
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module adc_result_fifo #(
   parameter int DEPTH = adc_result_fifo_pkg::DEPTH,
   parameter int HALF_LEVEL = adc_result_fifo_pkg::HALF_LEVEL
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Converter core, same clock
   input wire logic eoc,
   input wire adc_result_fifo_pkg::result_type convResult,
   // Host pins, asynchronous
   input wire logic pathSel,
   input wire logic readStrobe,
   input wire logic codeSel,
   input wire logic outEnN,
   // Data pins, enable low while driving
   output logic [15:0] dataOut,
   output logic msbOut,
   output logic msbBarOut,
   output logic ovfOut,
   output logic dataOeN,
   // Fill status pins
   output logic fillFlagHigh,
   output logic fillFlagLow,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [CW-1:0] HALF_CNT = CW'(HALF_LEVEL);
   localparam logic [CW-1:0] ONE_CNT = CW'(1);
   localparam logic [CW-1:0] TWO_CNT = CW'(2);

   // Fill level to status code
   // status code mapping
   function automatic logic [1:0] fillCode(input logic [CW-1:0] cnt);
      if (cnt == '0) begin
         fillCode = adc_result_fifo_pkg::FILL_EMPTY;
      end else if (cnt == FULL_CNT) begin
         fillCode = adc_result_fifo_pkg::FILL_FULL;
      end else if (cnt >= HALF_CNT) begin
         fillCode = adc_result_fifo_pkg::FILL_HALF;
      end else begin
         fillCode = adc_result_fifo_pkg::FILL_LOW;
      end
   endfunction

   // Word to pin code; high select complements every bit
   function automatic adc_result_fifo_pkg::result_type codeWord(
         input adc_result_fifo_pkg::result_type w, input logic sel);
      codeWord = sel ? ~w : w;
   endfunction

   // Two-stage synchronisers for the host pins
   logic [3:0] syncA; // First stage, read only by second stage
   logic [3:0] syncB; // Second stage, safe to use
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         // Strobe idles high, path direct: no false strobe edge after reset
         syncA <= 4'h2;
         syncB <= 4'h2;
      end else begin
         syncA <= {codeSel, outEnN, readStrobe, pathSel};
         syncB <= syncA;
      end
   end

   logic pathS, strobeS, codeS, oenS;
   assign pathS = syncB[0];
   assign strobeS = syncB[1];
   assign oenS = syncB[2];
   assign codeS = syncB[3];

   // Buffer storage, written only on accepted results
   adc_result_fifo_pkg::result_type mem [DEPTH];

   // Buffer state
   logic [PW-1:0] wrPtr, next_wrPtr; // Next free slot
   logic [PW-1:0] rdPtr, next_rdPtr; // Presented slot
   logic [CW-1:0] count, next_count; // Words held, presented one included
   logic drainArm, next_drainArm; // Last word presented by a read
   logic strobePrev, next_strobePrev; // For edge detection
   logic eocPrev, next_eocPrev; // For end of conversion detection
   logic lost, next_lost; // Sticky: a result was discarded
   adc_result_fifo_pkg::result_type direct, next_direct; // Latest result
   adc_result_fifo_pkg::result_type held, next_held; // Word kept after empty
   logic flushReq; // Software flush pulse from the bus
   logic lostClr; // Software clear of the lost flag
   logic doWrite; // Result accepted into storage

   // Next buffer state
   always_comb begin
      logic convDone, rise, fall;
      convDone = eocPrev & ~eoc;
      rise = strobeS & ~strobePrev;
      fall = ~strobeS & strobePrev;
      next_wrPtr = wrPtr;
      next_rdPtr = rdPtr;
      next_count = count;
      next_drainArm = drainArm;
      next_strobePrev = strobeS;
      next_eocPrev = eoc;
      next_direct = convDone ? convResult : direct;
      next_held = held;
      next_lost = lost & ~lostClr;
      doWrite = 1'b0;
      // flush on direct mode with strobe low
      if ((~pathS & ~strobeS) | flushReq) begin
         next_wrPtr = '0;
         next_rdPtr = '0;
         next_count = '0;
         next_drainArm = 1'b0;
      end else if (pathS) begin
         if (convDone) begin
            if (count == FULL_CNT) begin
               next_lost = 1'b1;
            end else begin
               doWrite = 1'b1;
               next_wrPtr = wrPtr + PW'(1);
            end
         end
         if (rise && count > ONE_CNT) begin
            next_rdPtr = rdPtr + PW'(1);
         end
         if (rise && count != '0) begin
            next_drainArm = (count <= TWO_CNT) & ~(doWrite & (count == TWO_CNT));
         end
         // falling edge after last word empties
         if (fall && drainArm && count == ONE_CNT && !doWrite) begin
            next_count = '0;
            next_drainArm = 1'b0;
            next_held = mem[rdPtr];
            next_rdPtr = wrPtr;
         end else begin
            next_count = count + CW'(doWrite) - CW'(rise && count > ONE_CNT);
         end
         // Fresh word after the last one cancels the drain
         if (doWrite && count != '0) begin
            next_drainArm = 1'b0;
         end
      end
      // host keeps strobe and pins steady; no guard here
   end

   // Buffer registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
         drainArm <= 1'b0;
         strobePrev <= 1'b1;
         eocPrev <= 1'b0;
         lost <= 1'b0;
         direct <= adc_result_fifo_pkg::RESET_WORD;
         held <= adc_result_fifo_pkg::RESET_WORD;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
         drainArm <= next_drainArm;
         strobePrev <= next_strobePrev;
         eocPrev <= next_eocPrev;
         lost <= next_lost;
         direct <= next_direct;
         held <= next_held;
      end
   end

   // Storage array, no reset needed on data
   always_ff @(posedge ref_clk) begin
      if (doWrite) begin
         mem[wrPtr] <= convResult;
      end
   end

   // Output word and pin drive
   adc_result_fifo_pkg::result_type pinWord, next_pinWord;
   logic next_oeN;
   logic [1:0] flags, next_flags;
   always_comb begin
      adc_result_fifo_pkg::result_type src;
      src = direct;
      if (pathS) begin
         // head word, or last word once empty
         src = (next_count == '0) ? next_held : mem[next_rdPtr];
         if (doWrite && count == '0) begin
            src = convResult;
         end
      end
      next_pinWord = codeWord(src, codeS);
      next_oeN = oenS;
      // flags follow the new level next edge
      next_flags = fillCode(next_count);
   end

   // Output registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pinWord <= adc_result_fifo_pkg::RESET_WORD;
         dataOeN <= 1'b1;
         flags <= adc_result_fifo_pkg::FILL_EMPTY;
      end else begin
         // one edge after the synchronised change
         pinWord <= next_pinWord;
         dataOeN <= next_oeN;
         flags <= next_flags;
      end
   end

   // Pins come straight from the output registers
   assign dataOut = pinWord.data;
   assign msbOut = pinWord.msb;
   assign ovfOut = pinWord.ovf;
   assign fillFlagHigh = flags[1];
   assign fillFlagLow = flags[0];

   // Inverted msb pin has its own flop so it stays registered
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         msbBarOut <= 1'b1;
      end else begin
         msbBarOut <= ~next_pinWord.msb;
      end
   end

   // APB slave: one wait state, answer registered
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   always_comb begin
      logic access;
      logic [31:0] rd;
      access = psel & penable & ~pready;
      rd = adc_result_fifo_pkg::RESET_PRDATA;
      next_prdata = prdata;
      next_pready = access;
      next_pslverr = 1'b0;
      flushReq = 1'b0;
      lostClr = 1'b0;
      unique case (paddr)
         adc_result_fifo_pkg::OFS_STATUS: begin
            rd[adc_result_fifo_pkg::ST_FLAGS_LSB +: 2] = flags;
            rd[adc_result_fifo_pkg::ST_COUNT_LSB +: 5] = 5'(count);
            rd[adc_result_fifo_pkg::ST_LOST_BIT] = lost;
            rd[adc_result_fifo_pkg::ST_MODE_BIT] = pathS;
         end
         adc_result_fifo_pkg::OFS_CTRL: begin
            rd = adc_result_fifo_pkg::RESET_PRDATA;
         end
         adc_result_fifo_pkg::OFS_DATA: begin
            rd[17:0] = pinWord;
         end
         default: begin
            // Unmapped offset answers with an error
            next_pslverr = access;
         end
      endcase
      if (access) begin
         next_prdata = pwrite ? adc_result_fifo_pkg::RESET_PRDATA : rd;
         if (pwrite && paddr == adc_result_fifo_pkg::OFS_CTRL) begin
            flushReq = pwdata[adc_result_fifo_pkg::CT_FLUSH_BIT];
         end
         // Write one clears; a discard in the same cycle still sets
         if (pwrite && paddr == adc_result_fifo_pkg::OFS_STATUS) begin
            lostClr = pwdata[adc_result_fifo_pkg::ST_LOST_BIT];
         end
      end
   end

   // APB registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prdata <= adc_result_fifo_pkg::RESET_PRDATA;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end
endmodule // adc_result_fifo

// [rtl/adc_result_fifo_pkg.sv]
// Constants and types shared by the conversion result buffer
package adc_result_fifo_pkg;
   // Result word: overflow, most significant bit copy, sixteen data bits
   typedef struct packed {
      logic ovf;
      logic msb;
      logic [15:0] data;
   } result_type;

   // Buffer geometry
   localparam int DEPTH = 16;
   localparam int HALF_LEVEL = 8;

   // Fill status codes, high flag then low flag
   localparam logic [1:0] FILL_EMPTY = 2'h1;
   localparam logic [1:0] FILL_LOW = 2'h0;
   localparam logic [1:0] FILL_HALF = 2'h2;
   localparam logic [1:0] FILL_FULL = 2'h3;

   // Register byte offsets
   localparam logic [11:0] OFS_STATUS = 12'h000;
   localparam logic [11:0] OFS_CTRL = 12'h004;
   localparam logic [11:0] OFS_DATA = 12'h008;

   // Status register fields
   localparam int ST_FLAGS_LSB = 0;
   localparam int ST_COUNT_LSB = 2;
   localparam int ST_LOST_BIT = 7;
   localparam int ST_MODE_BIT = 8;

   // Control register fields
   localparam int CT_FLUSH_BIT = 0;

   // Reset values
   localparam logic [31:0] RESET_PRDATA = 32'h0000_0000;
   localparam logic [17:0] RESET_WORD = 18'h00000;

   // Clock and timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int SYNC_STAGES = 2;
   localparam int READ_VALID_MAX_NS = 40;
   localparam int READ_VALID_CYCLES =
      (READ_VALID_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (READ_VALID_MAX_NS / CLK_PERIOD_NS);
endpackage

// [verif/adc_result_fifo_props.sv]
// Concurrent checks on the result buffer pins and APB port
`timescale 1ns/1ps
module adc_result_fifo_props (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Converter and host pins
   input wire logic eoc,
   input wire logic pathSel,
   input wire logic readStrobe,
   input wire logic outEnN,
   // Outputs under check
   input wire logic msbOut,
   input wire logic msbBarOut,
   input wire logic dataOeN,
   input wire logic fillFlagHigh,
   input wire logic fillFlagLow,
   // APB handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Fill code, high flag first
   logic [1:0] fill;
   assign fill = {fillFlagHigh, fillFlagLow};
   AST_MSB_BAR: assert property (msbBarOut == !msbOut)
      else $error("inverted msb pin disagrees");
   AST_FIRST_WRITE: assert property (
      $fell(eoc) && pathSel && $past(pathSel, 3) && fill == 2'h1 |-> ##[1:3] fill == 2'h0)
      else $error("first write did not leave empty");
   // Strobe held high so no read can move the level
   AST_FULL_KEEP: assert property (
      $fell(eoc) && pathSel && readStrobe && fill == 2'h3 |=> $stable(fill)[*3])
      else $error("write into full buffer changed status");
   AST_DIRECT: assert property (
      $fell(eoc) && !pathSel && !$past(pathSel, 3) && readStrobe |=> $stable(fill)[*3])
      else $error("direct mode write reached buffer");
   AST_PIN_RESET: assert property ((!pathSel && !readStrobe)[*5] |-> fill == 2'h1)
      else $error("pin reset did not empty buffer");
   AST_OE_OFF: assert property (outEnN[*4] |-> dataOeN)
      else $error("data pins driven while disabled");
   AST_OE_ON: assert property (!outEnN[*4] |-> !dataOeN)
      else $error("data pins not driven while enabled");
   AST_ANSWER: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered after one wait state");
   AST_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
endmodule // adc_result_fifo_props
bind adc_result_fifo adc_result_fifo_props u_props (.ref_clk, .rst, .eoc, .pathSel,
   .readStrobe, .outEnN, .msbOut, .msbBarOut, .dataOeN, .fillFlagHigh, .fillFlagLow, .psel,
   .penable, .pready);

// [verif/host_pin_model.sv]
// Host model that pulses the read strobe pin on request
`timescale 1ns/1ps
module host_pin_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Requests from the bench
   input wire logic reqRead,
   input wire logic holdLow,
   input wire logic slow,
   // Strobe pin and progress
   output logic readStrobe,
   output logic busy
);
   logic [3:0] cnt; // Cycles left in the pulse
   logic level; // Strobe level before the hold
   // idle high; held low on demand
   assign readStrobe = level & ~holdLow;
   assign busy = cnt != 4'h0;
   // low first, then one rising edge; slow keeps each level six cycles
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt <= 4'h0;
         level <= 1'b1;
      end else if (reqRead && !busy) begin
         cnt <= slow ? 4'hc : 4'h4;
         level <= 1'b0;
      end else if (busy) begin
         cnt <= cnt - 4'h1;
         // Rising edge halfway through
         if (cnt == (slow ? 4'h7 : 4'h3)) level <= 1'b1;
      end
   end
endmodule // host_pin_model

// [verif/tb_top.sv]
// Self-checking bench for the conversion result buffer
`timescale 1ns/1ps
module tb_top;
   logic ref_clk, rst, eoc, pathSel, codeSel, outEnN, reqRead, holdLow, slow, readStrobe, busy;
   logic psel, penable, pwrite, pready, pslverr, msbOut, msbBarOut, ovfOut, dataOeN;
   logic fillFlagHigh, fillFlagLow;
   adc_result_fifo_pkg::result_type convResult;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] dataOut;
   int miscompares, comparisons;
   adc_result_fifo u_adc_result_fifo (.ref_clk, .rst, .eoc, .convResult, .pathSel, .readStrobe,
      .codeSel, .outEnN, .dataOut, .msbOut, .msbBarOut, .ovfOut, .dataOeN, .fillFlagHigh,
      .fillFlagLow, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   host_pin_model u_host_pin_model (.ref_clk, .rst, .reqRead, .holdLow, .slow, .readStrobe,
      .busy);
   always #10 ref_clk = ~ref_clk;
   // Value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Expected status code for a word count
   function automatic logic [1:0] fl(input int n);
      if (n == 0) return adc_result_fifo_pkg::FILL_EMPTY;
      if (n == 16) return adc_result_fifo_pkg::FILL_FULL;
      return n >= 8 ? adc_result_fifo_pkg::FILL_HALF : adc_result_fifo_pkg::FILL_LOW;
   endfunction
   // One conversion, result valid as eoc falls
   task automatic conv(input adc_result_fifo_pkg::result_type w);
      eoc <= 1;
      repeat (2) @(posedge ref_clk);
      convResult <= w;
      eoc <= 0;
      repeat (5) @(posedge ref_clk);
   endtask
   // One strobe pulse through the host model
   task automatic rd(input logic s);
      slow <= s;
      reqRead <= 1;
      @(posedge ref_clk);
      reqRead <= 0;
      @(posedge ref_clk);
      // Waits out the whole pulse; the hang guard ends a stuck model
      while (busy === 1'b1) @(posedge ref_clk);
      repeat (5) @(posedge ref_clk);
   endtask
   // APB transfer, waits for ready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      // No assumed latency: only the hang guard ends this wait
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   initial begin
      adc_result_fifo_pkg::result_type q[$];
      adc_result_fifo_pkg::result_type w;
      logic [31:0] r;
      logic e;
      {ref_clk, eoc, codeSel, outEnN, reqRead, holdLow, slow, psel, penable, pwrite} = '0;
      {rst, pathSel} = 2'h3;
      convResult = '0;
      paddr = '0;
      pwdata = '0;
      void'($urandom(31426));
      repeat (5) @(posedge ref_clk);
      rst <= 0;
      repeat (3) @(posedge ref_clk);
      // Fill past full, all-ones corner first
      for (int i = 1; i <= 17; i++) begin
         w = adc_result_fifo_pkg::result_type'(i == 1 ? 18'h3ffff : 18'($urandom));
         if (i <= 16) q.push_back(w);
         conv(w);
         chk({fillFlagHigh, fillFlagLow}, fl(i > 16 ? 16 : i));
         chk({ovfOut, msbOut, dataOut}, q[0]);
      end
      // Drain, one slow strobe, the last read empties the buffer
      for (int i = 1; i <= 16; i++) begin
         rd(i == 5);
         chk({fillFlagHigh, fillFlagLow}, fl(i == 16 ? 0 : 16 - i));
         chk({ovfOut, msbOut, dataOut}, q[i > 15 ? 15 : i]);
      end
      // Direct mode, complemented code
      codeSel <= 1;
      pathSel <= 0;
      repeat (4) @(posedge ref_clk);
      w = adc_result_fifo_pkg::result_type'(18'($urandom));
      conv(w);
      chk({ovfOut, msbOut, dataOut}, 18'(~w));
      chk({fillFlagHigh, fillFlagLow}, fl(0));
      outEnN <= 1;
      repeat (5) @(posedge ref_clk);
      chk(dataOeN, 1);
      outEnN <= 0;
      codeSel <= 0;
      pathSel <= 1;
      q = {};
      repeat (5) @(posedge ref_clk);
      for (int i = 0; i < 3; i++) begin
         q.push_back(adc_result_fifo_pkg::result_type'(18'($urandom)));
         conv(q[i]);
      end
      apb(0, adc_result_fifo_pkg::OFS_STATUS, '0, r, e);
      chk(r[8:0], {1'b1, 1'b1, 5'h03, fl(3)});
      apb(0, adc_result_fifo_pkg::OFS_DATA, '0, r, e);
      chk(r, {14'h0, q[0]});
      // Clear the sticky discard flag, checked in the last status read
      apb(1, adc_result_fifo_pkg::OFS_STATUS, 32'h80, r, e);
      // Pin reset: direct mode with strobe low
      holdLow <= 1;
      pathSel <= 0;
      repeat (5) @(posedge ref_clk);
      chk({fillFlagHigh, fillFlagLow}, fl(0));
      holdLow <= 0;
      pathSel <= 1;
      repeat (4) @(posedge ref_clk);
      conv(q[1]);
      apb(1, adc_result_fifo_pkg::OFS_CTRL, 32'h1, r, e);
      apb(0, adc_result_fifo_pkg::OFS_STATUS, '0, r, e);
      chk(r[8:0], {1'b1, 1'b0, 5'h00, fl(0)});
      apb(0, 12'hffc, '0, r, e);
      chk(e, 1);
      end_of_test();
   end
   // Hang guard
   initial begin
      #100us;
      miscompares++;
      end_of_test();
   end
endmodule // tb_top
